// *** hdl/wiper_master.sv ***
// Bus master that writes or reads the wiper register on command
module wiper_master (
	input  wire logic               CLK_SYS,
	input  wire logic               RST,
	input  wire logic               CE,
	i2c_link_if.master              LINK,
	input  wire logic [1:0]         ADDR,
	input  wire logic [7:0]         WDATA,
	input  wire logic               WR,
	input  wire logic               RD,
	output logic      [7:0]         RDATA
);
	import wiper_pkg::*;

	typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} mstate_t;

	mstate_t          state_reg, state_next;
	logic [QTR_W-1:0] qcnt_reg, qcnt_next;
	logic [1:0]       quarter_reg, quarter_next;
	logic [3:0]       bit_cnt_reg, bit_cnt_next;
	logic [1:0]       idx_reg, idx_next;
	logic [7:0]       byte_reg, byte_next;
	logic [7:0]       txdata_reg, txdata_next;
	logic [7:0]       rxdata_reg, rxdata_next;
	logic [7:0]       rdata_reg, rdata_next;
	logic             read_reg, read_next;
	logic             nack_reg, nack_next;
	logic             done_reg, done_next;
	logic             scl_oe_reg, scl_oe_next;
	logic             sda_oe_reg, sda_oe_next;
	logic             sda_s1_reg, sda_s2_reg;
	logic             tick;
	logic             last_byte;
	logic             rx_byte;

	// ----------------------------------------
	// Byte sequence
	// ----------------------------------------
	// R5 R6 R7 R11 byte order
	function automatic logic [7:0] byte_for(input logic [1:0] idx, input logic rd,
		input logic [7:0] tx);
		logic [7:0] b;
		b = 8'hff;
		case (idx)
			2'h0: b = {DEV_ID, DIR_WRITE};
			2'h1: b = WIPER_ADDR;
			2'h2: b = rd ? {DEV_ID, DIR_READ} : tx;
			default: b = 8'hff;
		endcase
		return b;
	endfunction

	assign tick      = (qcnt_reg == QTR_W'(QTR_CYCLES - 1));
	assign last_byte = read_reg ? (idx_reg == 2'h3) : (idx_reg == 2'h2);
	assign rx_byte   = read_reg && (idx_reg == 2'h3);

	// ----------------------------------------
	// Sequencer and registers
	// ----------------------------------------
	always_comb begin
		state_next   = state_reg;
		qcnt_next    = qcnt_reg;
		quarter_next = quarter_reg;
		bit_cnt_next = bit_cnt_reg;
		idx_next     = idx_reg;
		byte_next    = byte_reg;
		txdata_next  = txdata_reg;
		rxdata_next  = rxdata_reg;
		read_next    = read_reg;
		nack_next    = nack_reg;
		done_next    = done_reg;
		scl_oe_next  = scl_oe_reg;
		sda_oe_next  = sda_oe_reg;
		rdata_next   = 8'h00;
		if (RD) begin
			case (ADDR)
				TXDATA_OFS: rdata_next = txdata_reg;
				RXDATA_OFS: rdata_next = rxdata_reg;
				STATUS_OFS: rdata_next = {5'h00, done_reg, nack_reg, state_reg != M_IDLE};
				default:    rdata_next = {6'h00, read_reg, 1'h0};
			endcase
		end
		if (WR && ADDR == TXDATA_OFS) begin
			txdata_next = WDATA;
		end
		if (state_reg == M_IDLE) begin
			qcnt_next = '0;
			if (WR && ADDR == CTRL_OFS && WDATA[CTRL_GO_BIT]) begin
				read_next    = WDATA[CTRL_READ_BIT];
				nack_next    = 1'h0;
				done_next    = 1'h0;
				idx_next     = 2'h0;
				quarter_next = 2'h0;
				state_next   = M_START;
				scl_oe_next  = 1'h1;
				sda_oe_next  = 1'h0;
			end
		end else if (tick) begin
			qcnt_next    = '0;
			quarter_next = quarter_reg + 2'h1;
			case (state_reg)
				M_START: begin
					case (quarter_reg)
						2'h0: scl_oe_next = 1'h0;
						2'h1: sda_oe_next = 1'h1;
						2'h2: scl_oe_next = 1'h1;
						default: begin
							byte_next    = byte_for(idx_reg, read_reg, txdata_reg);
							bit_cnt_next = 4'h0;
							state_next   = M_BIT;
							sda_oe_next  = ~byte_next[7];
						end
					endcase
				end
				M_BIT: begin
					case (quarter_reg)
						2'h0: scl_oe_next = 1'h0;
						2'h1: begin
						end
						2'h2: begin
							scl_oe_next = 1'h1;
							if (bit_cnt_reg < BITS_PER_BYTE) begin
								// R14 msb first
								byte_next = {byte_reg[6:0], sda_s2_reg};
							end else if (!rx_byte) begin
								nack_next = sda_s2_reg;
							end
						end
						default: begin
							if (bit_cnt_reg < BITS_PER_BYTE) begin
								bit_cnt_next = bit_cnt_reg + 4'h1;
								sda_oe_next  = (bit_cnt_reg == BITS_PER_BYTE - 4'h1) ?
									1'h0 : ~byte_reg[7];
							end else if (nack_reg || last_byte) begin
								// R13 end read with stop
								if (rx_byte) begin
									rxdata_next = byte_reg;
								end
								state_next  = M_STOP;
								sda_oe_next = 1'h1;
							end else if (read_reg && idx_reg == 2'h1) begin
								idx_next    = 2'h2;
								state_next  = M_START;
								sda_oe_next = 1'h0;
							end else begin
								idx_next     = idx_reg + 2'h1;
								bit_cnt_next = 4'h0;
								byte_next    = byte_for(idx_reg + 2'h1, read_reg, txdata_reg);
								sda_oe_next  = ~byte_next[7];
							end
						end
					endcase
				end
				M_STOP: begin
					case (quarter_reg)
						2'h0: scl_oe_next = 1'h0;
						2'h1: sda_oe_next = 1'h0;
						2'h2: begin
						end
						default: begin
							state_next = M_IDLE;
							done_next  = 1'h1;
						end
					endcase
				end
				default: state_next = M_IDLE;
			endcase
		end else begin
			qcnt_next = qcnt_reg + QTR_W'(1);
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			state_reg   <= M_IDLE;
			qcnt_reg    <= '0;
			quarter_reg <= 2'h0;
			bit_cnt_reg <= 4'h0;
			idx_reg     <= 2'h0;
			byte_reg    <= 8'h00;
			txdata_reg  <= TXDATA_RESET;
			rxdata_reg  <= RXDATA_RESET;
			rdata_reg   <= 8'h00;
			read_reg    <= 1'h0;
			nack_reg    <= 1'h0;
			done_reg    <= 1'h0;
			scl_oe_reg  <= 1'h0;
			sda_oe_reg  <= 1'h0;
			sda_s1_reg  <= 1'h1;
			sda_s2_reg  <= 1'h1;
		end else if (CE) begin
			state_reg   <= state_next;
			qcnt_reg    <= qcnt_next;
			quarter_reg <= quarter_next;
			bit_cnt_reg <= bit_cnt_next;
			idx_reg     <= idx_next;
			byte_reg    <= byte_next;
			txdata_reg  <= txdata_next;
			rxdata_reg  <= rxdata_next;
			rdata_reg   <= rdata_next;
			read_reg    <= read_next;
			nack_reg    <= nack_next;
			done_reg    <= done_next;
			scl_oe_reg  <= scl_oe_next;
			sda_oe_reg  <= sda_oe_next;
			sda_s1_reg  <= LINK.sda;
			sda_s2_reg  <= sda_s1_reg;
		end
	end

	assign LINK.scl_m_out = 1'h0;
	assign LINK.sda_m_out = 1'h0;
	assign LINK.scl_m_oe  = scl_oe_reg;
	assign LINK.sda_m_oe  = sda_oe_reg;
	assign RDATA          = rdata_reg;

endmodule

// *** hdl/wiper_pkg.sv ***
// Shared constants for the wiper register slave and its bus master
package wiper_pkg;

	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS  = 4;
	localparam int SCL_PERIOD_NS  = 64;
	localparam int QTR_CYCLES     = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
	localparam int POWERUP_NS     = 1000;
	localparam int POWERUP_CYCLES = (POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int QTR_W          = $clog2(QTR_CYCLES + 1);
	localparam int PWR_W          = $clog2(POWERUP_CYCLES + 1);

	// ----------------------------------------
	// Serial protocol
	// ----------------------------------------
	// Device code value is arbitrary
	localparam logic [6:0] DEV_ID        = 7'h3c;
	localparam logic       DIR_WRITE     = 1'h0;
	localparam logic       DIR_READ      = 1'h1;
	localparam logic [7:0] WIPER_ADDR    = 8'h00;
	localparam logic [7:0] WIPER_RESET   = 8'h80;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// ----------------------------------------
	// Master command registers
	// ----------------------------------------
	localparam logic [1:0] CTRL_OFS      = 2'h0;
	localparam logic [1:0] TXDATA_OFS    = 2'h1;
	localparam logic [1:0] RXDATA_OFS    = 2'h2;
	localparam logic [1:0] STATUS_OFS    = 2'h3;
	localparam int         CTRL_GO_BIT   = 0;
	localparam int         CTRL_READ_BIT = 1;
	localparam int         STAT_BUSY_BIT = 0;
	localparam int         STAT_NACK_BIT = 1;
	localparam int         STAT_DONE_BIT = 2;
	localparam logic [7:0] TXDATA_RESET  = 8'h00;
	localparam logic [7:0] RXDATA_RESET  = 8'h00;

endpackage

// *** hdl/i2c_link_if.sv ***
// Two-wire link between bus master and wiper slave, open-drain resolved here
interface i2c_link_if;

	logic scl_m_out;
	logic scl_m_oe;
	logic sda_m_out;
	logic sda_m_oe;
	logic sda_s_out;
	logic sda_s_oe;
	logic scl;
	logic sda;

	// ----------------------------------------
	// Wired-AND with pull-up
	// ----------------------------------------
	assign scl = scl_m_oe ? scl_m_out : 1'h1;
	assign sda = (sda_m_oe ? sda_m_out : 1'h1) & (sda_s_oe ? sda_s_out : 1'h1);

	modport master (
		output scl_m_out,
		output scl_m_oe,
		output sda_m_out,
		output sda_m_oe,
		input  scl,
		input  sda
	);

	modport slave (
		output sda_s_out,
		output sda_s_oe,
		input  scl,
		input  sda
	);

endinterface

// *** hdl/wiper_slave.sv ***
// Two-wire slave holding the 8-bit wiper position register
// Behaviour
// R1: Ack matching identification byte in ninth clock
// R2: Ack valid address byte in ninth clock
// R3: Ack written data byte after eighth bit
// R4: Master acks read bytes it wants continued
// R5: Seven-bit code plus direction bit, 1 reads
// R6: Address byte is 00h, selects wiper
// R7: Write is start, id, address, data, stop
// R8: Return to standby after write completes
// R9: Load wiper on falling edge after LSB
// R10: Update only with valid bytes, exact count
// R11: Read uses repeated start, id with read
// R12: Keep sending bytes while master acks
// R13: Master ends read with ack clock, stop
// R14: Every byte goes most significant bit first
// R15: Wiper powers up at 80h
// R16: Ignore start conditions during power-up
// R17: Wrong code: no ack, wait for start
module wiper_slave (
	input  wire logic               CLK_SYS,
	input  wire logic               RST,
	input  wire logic               CE,
	i2c_link_if.slave               LINK,
	output logic      [7:0]         WIPER,
	output logic                    ACTIVE
);
	import wiper_pkg::*;

	typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_TXACK} sstate_t;
	typedef enum logic [1:0] {PH_ID, PH_ADDR, PH_DATA} phase_t;

	sstate_t          state_reg, state_next;
	phase_t           phase_reg, phase_next;
	logic [7:0]       shift_reg, shift_next;
	logic [3:0]       bit_cnt_reg, bit_cnt_next;
	logic [7:0]       wiper_reg, wiper_next;
	logic [PWR_W-1:0] pwr_cnt_reg, pwr_cnt_next;
	logic             ready_reg, ready_next;
	logic             read_reg, read_next;
	logic             mack_reg, mack_next;
	logic             sda_oe_reg, sda_oe_next;
	logic             active_reg, active_next;
	logic             scl_s1_reg, scl_s2_reg, scl_s3_reg;
	logic             sda_s1_reg, sda_s2_reg, sda_s3_reg;
	logic             scl_rise;
	logic             scl_fall;
	logic             start_seen;
	logic             stop_seen;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Edges are taken between stages two and three, never from stage one
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			scl_s1_reg <= 1'h1;
			scl_s2_reg <= 1'h1;
			scl_s3_reg <= 1'h1;
			sda_s1_reg <= 1'h1;
			sda_s2_reg <= 1'h1;
			sda_s3_reg <= 1'h1;
		end else if (CE) begin
			scl_s1_reg <= LINK.scl;
			scl_s2_reg <= scl_s1_reg;
			scl_s3_reg <= scl_s2_reg;
			sda_s1_reg <= LINK.sda;
			sda_s2_reg <= sda_s1_reg;
			sda_s3_reg <= sda_s2_reg;
		end
	end

	assign scl_rise   = scl_s2_reg && !scl_s3_reg;
	assign scl_fall   = !scl_s2_reg && scl_s3_reg;
	assign start_seen = scl_s2_reg && scl_s3_reg && !sda_s2_reg && sda_s3_reg;
	assign stop_seen  = scl_s2_reg && scl_s3_reg && sda_s2_reg && !sda_s3_reg;

	// ----------------------------------------
	// Protocol engine
	// ----------------------------------------
	always_comb begin
		state_next   = state_reg;
		phase_next   = phase_reg;
		shift_next   = shift_reg;
		bit_cnt_next = bit_cnt_reg;
		wiper_next   = wiper_reg;
		pwr_cnt_next = pwr_cnt_reg;
		ready_next   = ready_reg;
		read_next    = read_reg;
		mack_next    = mack_reg;
		sda_oe_next  = sda_oe_reg;
		// R16 power-up hold-off
		if (!ready_reg) begin
			pwr_cnt_next = pwr_cnt_reg + PWR_W'(1);
			ready_next   = (pwr_cnt_reg == PWR_W'(POWERUP_CYCLES - 1));
		end
		if (start_seen && ready_reg) begin
			state_next   = S_RX;
			phase_next   = PH_ID;
			bit_cnt_next = 4'h0;
			sda_oe_next  = 1'h0;
		end else if (stop_seen) begin
			state_next  = S_IDLE;
			sda_oe_next = 1'h0;
		end else begin
			case (state_reg)
				S_RX: begin
					if (scl_rise) begin
						// R14 msb arrives first
						shift_next   = {shift_reg[6:0], sda_s2_reg};
						bit_cnt_next = bit_cnt_reg + 4'h1;
					end else if (scl_fall && bit_cnt_reg == BITS_PER_BYTE) begin
						bit_cnt_next = 4'h0;
						case (phase_reg)
							PH_ID: begin
								// R1 R5 R17 code check
								if (shift_reg[7:1] == DEV_ID) begin
									read_next   = (shift_reg[0] == DIR_READ);
									sda_oe_next = 1'h1;
									state_next  = S_ACK;
								end else begin
									state_next = S_IDLE;
								end
							end
							PH_ADDR: begin
								// R2 R6 address check
								if (shift_reg == WIPER_ADDR) begin
									sda_oe_next = 1'h1;
									state_next  = S_ACK;
								end else begin
									state_next = S_IDLE;
								end
							end
							default: begin
								// R9 R10 load on LSB falling edge
								wiper_next  = shift_reg;
								// R3 data ack
								sda_oe_next = 1'h1;
								state_next  = S_ACK;
							end
						endcase
					end
				end
				S_ACK: begin
					if (scl_fall) begin
						sda_oe_next  = 1'h0;
						bit_cnt_next = 4'h0;
						case (phase_reg)
							PH_ID: begin
								if (read_reg) begin
									shift_next  = wiper_reg;
									sda_oe_next = ~wiper_reg[7];
									state_next  = S_TX;
								end else begin
									phase_next = PH_ADDR;
									state_next = S_RX;
								end
							end
							PH_ADDR: begin
								phase_next = PH_DATA;
								state_next = S_RX;
							end
							default: begin
								// R8 back to standby
								state_next = S_IDLE;
							end
						endcase
					end
				end
				S_TX: begin
					if (scl_rise) begin
						bit_cnt_next = bit_cnt_reg + 4'h1;
					end else if (scl_fall) begin
						if (bit_cnt_reg == BITS_PER_BYTE) begin
							sda_oe_next = 1'h0;
							state_next  = S_TXACK;
						end else begin
							// R14 next lower bit
							shift_next  = {shift_reg[6:0], 1'h0};
							sda_oe_next = ~shift_reg[6];
						end
					end
				end
				S_TXACK: begin
					if (scl_rise) begin
						mack_next = !sda_s2_reg;
					end else if (scl_fall) begin
						// R4 R12 continue while acked
						if (mack_reg) begin
							shift_next   = wiper_reg;
							sda_oe_next  = ~wiper_reg[7];
							bit_cnt_next = 4'h0;
							state_next   = S_TX;
						end else begin
							state_next = S_IDLE;
						end
					end
				end
				default: begin
					sda_oe_next = 1'h0;
				end
			endcase
		end
		active_next = (state_next != S_IDLE);
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			state_reg   <= S_IDLE;
			phase_reg   <= PH_ID;
			shift_reg   <= 8'h00;
			bit_cnt_reg <= 4'h0;
			// R15 mid-scale at power-up
			wiper_reg   <= WIPER_RESET;
			pwr_cnt_reg <= '0;
			ready_reg   <= 1'h0;
			read_reg    <= 1'h0;
			mack_reg    <= 1'h0;
			sda_oe_reg  <= 1'h0;
			active_reg  <= 1'h0;
		end else if (CE) begin
			state_reg   <= state_next;
			phase_reg   <= phase_next;
			shift_reg   <= shift_next;
			bit_cnt_reg <= bit_cnt_next;
			wiper_reg   <= wiper_next;
			pwr_cnt_reg <= pwr_cnt_next;
			ready_reg   <= ready_next;
			read_reg    <= read_next;
			mack_reg    <= mack_next;
			sda_oe_reg  <= sda_oe_next;
			active_reg  <= active_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Open drain: only ever pulls low
	assign LINK.sda_s_out = 1'h0;
	assign LINK.sda_s_oe  = sda_oe_reg;
	assign WIPER          = wiper_reg;
	assign ACTIVE         = active_reg;

endmodule

// *** tb/wiper_link_checker.sv ***
// Protocol assertions on the two-wire link between master and slave
module wiper_link_checker (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic scl_m_out,
	input wire logic scl_m_oe,
	input wire logic sda_m_out,
	input wire logic sda_m_oe,
	input wire logic sda_s_out,
	input wire logic sda_s_oe,
	input wire logic scl,
	input wire logic sda
);
	timeunit 1ns;
	timeprecision 1ps;
	import wiper_pkg::*;

	// ----------------------------------------
	// Bit and byte tracking
	// ----------------------------------------
	logic [3:0]       cnt_reg;
	logic [1:0]       bidx_reg;
	logic [7:0]       sh_reg;
	logic [PWR_W-1:0] up_reg;
	logic             rd_reg;
	logic             ok_reg;
	logic             scl_reg;
	logic             sda_reg;
	logic             frame_reg;
	wire              rise  = scl & ~scl_reg;
	wire              start = scl & scl_reg & sda_reg & ~sda;
	wire              ninth = rise & (cnt_reg == 4'h8);
	wire              stop  = scl & scl_reg & ~sda_reg & sda;

	// Starts seen before the power-up count ends must be ignored
	always_ff @(posedge CLK_SYS) begin
		scl_reg <= scl;
		sda_reg <= sda;
		if (RST) begin
			up_reg   <= '0;
			cnt_reg  <= 4'h0;
			bidx_reg <= 2'h0;
			ok_reg   <= 1'b0;
			rd_reg   <= 1'b0;
			frame_reg <= 1'b0;
		end else begin
			if (up_reg != PWR_W'(POWERUP_CYCLES))
				up_reg <= up_reg + 1'b1;
			if (start)
				frame_reg <= 1'b1;
			else if (stop)
				frame_reg <= 1'b0;
			if (start) begin
				cnt_reg  <= 4'h0;
				bidx_reg <= 2'h0;
				ok_reg   <= (up_reg == PWR_W'(POWERUP_CYCLES));
			end else if (ninth) begin
				cnt_reg <= 4'h0;
				if (bidx_reg != 2'h3)
					bidx_reg <= bidx_reg + 2'h1;
				if (bidx_reg == 2'h0) begin
					ok_reg <= ok_reg && (sh_reg[7:1] == DEV_ID);
					rd_reg <= sh_reg[0];
				end
				if (bidx_reg == 2'h1 && !rd_reg)
					ok_reg <= ok_reg && (sh_reg == WIPER_ADDR);
			end else if (rise) begin
				cnt_reg <= cnt_reg + 4'h1;
				sh_reg  <= {sh_reg[6:0], sda};
			end
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_open_drain;
		@(posedge CLK_SYS) disable iff (RST) !scl_m_out && !sda_m_out && !sda_s_out;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("pin driven high");

	property p_scl_high;
		@(posedge CLK_SYS) disable iff (RST) $rose(scl) |-> scl [*8];
	endproperty
	a_scl_high: assert property (p_scl_high) else $error("clock high too short");

	property p_scl_low;
		@(posedge CLK_SYS) disable iff (RST) $fell(scl) && frame_reg |-> !scl [*8] ##1 scl;
	endproperty
	a_scl_low: assert property (p_scl_low) else $error("clock low wrong length");

	// The pull from idle lasts one quarter only, before the start sequence
	property p_scl_idle;
		@(posedge CLK_SYS) disable iff (RST) $fell(scl) && !frame_reg |-> !scl [*4] ##1 scl;
	endproperty
	a_scl_idle: assert property (p_scl_idle) else $error("idle clock pull wrong length");

	property p_answer_delay;
		@(posedge CLK_SYS) disable iff (RST) $changed(sda_s_oe) |-> !scl &&
			($past(scl, 2) || $past(scl, 3) || $past(scl, 4) || $past(scl, 5));
	endproperty
	a_answer_delay: assert property (p_answer_delay) else $error("slave moved data late");

	property p_ack_hold;
		@(posedge CLK_SYS) disable iff (RST) $rose(sda_s_oe) |=> sda_s_oe [*8];
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("slave bit not held");

	property p_ack_id;
		@(posedge CLK_SYS) disable iff (RST)
			ninth && bidx_reg == 2'h0 && ok_reg && sh_reg[7:1] == DEV_ID |-> !sda;
	endproperty
	a_ack_id: assert property (p_ack_id) else $error("id byte not acked");

	property p_ack_addr;
		@(posedge CLK_SYS) disable iff (RST)
			ninth && bidx_reg == 2'h1 && ok_reg && !rd_reg && sh_reg == WIPER_ADDR |-> !sda;
	endproperty
	a_ack_addr: assert property (p_ack_addr) else $error("address byte not acked");

	property p_ack_data;
		@(posedge CLK_SYS) disable iff (RST) ninth && bidx_reg == 2'h2 && ok_reg && !rd_reg |-> !sda;
	endproperty
	a_ack_data: assert property (p_ack_data) else $error("data byte not acked");

	property p_quiet;
		@(posedge CLK_SYS) disable iff (RST) ninth && !ok_reg |-> !sda_s_oe;
	endproperty
	a_quiet: assert property (p_quiet) else $error("slave acked ignored transfer");

	property p_stop_released;
		@(posedge CLK_SYS) disable iff (RST) scl && $rose(sda) |-> !sda_s_oe ##1 !sda_s_oe;
	endproperty
	a_stop_released: assert property (p_stop_released) else $error("slave holds data at stop");

	property p_read_nack;
		@(posedge CLK_SYS) disable iff (RST) ninth && bidx_reg == 2'h1 && rd_reg |-> !sda_m_oe;
	endproperty
	a_read_nack: assert property (p_read_nack) else $error("master acked last read byte");
endmodule

// *** tb/i2c_wiper_register_slave_bench.sv ***
// Self-checking bench for the wiper master and slave pair
module i2c_wiper_register_slave_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import wiper_pkg::*;

	logic        CLK_SYS = 1'b0;
	logic        RST     = 1'b1;
	logic        CE      = 1'b1;
	logic [1:0]  ADDR    = 2'h0;
	logic [7:0]  WDATA   = 8'h00;
	logic        WR      = 1'b0;
	logic        RD      = 1'b0;
	logic [7:0]  RDATA;
	logic [7:0]  WIPER;
	logic [7:0]  WIPER2;
	logic        ACTIVE;
	logic        ACTIVE2;
	logic [8:0]  exp_q[$];
	logic [8:0]  e;
	logic [7:0]  last_rd;
	logic [7:0]  ok_st;
	logic [7:0]  nack_st;
	logic [7:0]  d;
	logic [31:0] seed    = 32'hd9d029a4;
	logic        taken   = 1'b0;
	logic        a;
	int          fails       = 0;
	int          comparisons = 0;
	int          cycles      = 0;

	i2c_link_if link ();
	i2c_link_if link2 ();

	wiper_master wiper_master_i (.CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .LINK(link.master),
		.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA));
	wiper_slave wiper_slave_i (.CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .LINK(link.slave),
		.WIPER(WIPER), .ACTIVE(ACTIVE));
	// Second slave faces the bench, which breaks the protocol on purpose
	wiper_slave wiper_slave_i2 (.CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .LINK(link2.slave),
		.WIPER(WIPER2), .ACTIVE(ACTIVE2));
	wiper_link_checker wiper_link_checker_i (.CLK_SYS(CLK_SYS), .RST(RST),
		.scl_m_out(link.scl_m_out), .scl_m_oe(link.scl_m_oe), .sda_m_out(link.sda_m_out),
		.sda_m_oe(link.sda_m_oe), .sda_s_out(link.sda_s_out), .sda_s_oe(link.sda_s_oe),
		.scl(link.scl), .sda(link.sda));

	initial begin
		link2.scl_m_out = 1'b0;
		link2.sda_m_out = 1'b0;
		link2.scl_m_oe  = 1'b0;
		link2.sda_m_oe  = 1'b0;
	end

	always #(CLK_PERIOD_NS / 2.0) CLK_SYS = ~CLK_SYS;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		if (fails == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic wr(input logic [1:0] ad, input logic [7:0] v);
		ADDR  <= ad;
		WDATA <= v;
		WR    <= 1'b1;
		@(posedge CLK_SYS);
		WR <= 1'b0;
		@(posedge CLK_SYS);
	endtask

	// Bit 8 of the note says whether the read data is compared
	task automatic rd(input logic [1:0] ad, input logic [8:0] ex);
		ADDR <= ad;
		RD   <= 1'b1;
		exp_q.push_back(ex);
		@(posedge CLK_SYS);
		RD <= 1'b0;
		@(posedge CLK_SYS);
	endtask

	task automatic run(input logic rdop, input logic [7:0] st);
		logic [7:0] c;
		c = 8'h00;
		c[CTRL_GO_BIT] = 1'b1;
		c[CTRL_READ_BIT] = rdop;
		wr(CTRL_OFS, c);
		for (int i = 0; i < 2000; i++) begin
			rd(STATUS_OFS, 9'h000);
			if (last_rd[STAT_BUSY_BIT] === 1'b0)
				break;
		end
		rd(STATUS_OFS, {1'b1, st});
	endtask

	task automatic q(input logic c, input logic v);
		link2.scl_m_oe <= ~c;
		link2.sda_m_oe <= ~v;
		repeat (QTR_CYCLES) @(posedge CLK_SYS);
	endtask

	task automatic bb(input logic v, output logic s);
		q(1'b0, v);
		q(1'b1, v);
		q(1'b1, v);
		s = link2.sda;
		q(1'b0, v);
	endtask

	// MSB first, then a released ninth clock to catch the acknowledge
	task automatic tx(input logic [7:0] v, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bb(v[i], s);
		bb(1'b1, s);
		ack = ~s;
	endtask

	task automatic start2();
		q(1'b0, 1'b1);
		q(1'b1, 1'b1);
		q(1'b1, 1'b0);
		q(1'b0, 1'b0);
	endtask

	task automatic stop2();
		q(1'b0, 1'b0);
		q(1'b1, 1'b0);
		q(1'b1, 1'b1);
	endtask

	// ----------------------------------------
	// Monitor and timeout
	// ----------------------------------------
	always @(posedge CLK_SYS) begin
		taken <= RD;
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			$display("mismatch at %0t: timeout", $time);
			tally_and_finish();
		end
	end

	always @(negedge CLK_SYS) begin
		if (taken) begin
			last_rd = RDATA;
			e = exp_q.pop_front();
			if (e[8])
				check8(RDATA, e[7:0]);
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		ok_st = 8'h00;
		ok_st[STAT_DONE_BIT] = 1'b1;
		nack_st = ok_st;
		nack_st[STAT_NACK_BIT] = 1'b1;
		repeat (12) @(posedge CLK_SYS);
		RST <= 1'b0;
		@(posedge CLK_SYS);
		check8(WIPER, WIPER_RESET);
		wr(TXDATA_OFS, 8'h5a);
		run(1'b0, nack_st);
		check8(WIPER, WIPER_RESET);
		// Slave ignores starts until its power-up count has run out
		repeat (POWERUP_CYCLES) @(posedge CLK_SYS);
		for (int k = 0; k < 4; k++) begin
			seed = xs(seed);
			d = seed[7:0];
			wr(TXDATA_OFS, d);
			rd(TXDATA_OFS, {1'b1, d});
			run(1'b0, ok_st);
			check8(WIPER, d);
			check8({7'h00, ACTIVE}, 8'h00);
			run(1'b1, ok_st);
			rd(RXDATA_OFS, {1'b1, d});
		end
		start2();
		tx({DEV_ID ^ 7'h01, DIR_WRITE}, a);
		check8({7'h00, a}, 8'h00);
		check8({7'h00, ACTIVE2}, 8'h00);
		tx(WIPER_ADDR, a);
		tx(8'h11, a);
		stop2();
		start2();
		tx({DEV_ID, DIR_WRITE}, a);
		check8({7'h00, a}, 8'h01);
		check8({7'h00, ACTIVE2}, 8'h01);
		tx(8'h01, a);
		check8({7'h00, a}, 8'h00);
		tx(8'h5a, a);
		stop2();
		check8(WIPER2, WIPER_RESET);
		start2();
		tx({DEV_ID, DIR_WRITE}, a);
		tx(WIPER_ADDR, a);
		tx(8'hc3, a);
		check8({7'h00, a}, 8'h01);
		check8(WIPER2, 8'hc3);
		stop2();
		tally_and_finish();
	end
endmodule
